// [src/host_pkg.sv]
// Shared constants and types of the line-decoder host controller.
// Assumes a 50 MHz pclk and a decoder that is only a slave on its two-wire port.
package host_pkg;

  // Timing: the core clock and the chosen two-wire bit period.
  localparam int CLK_NS        = 20;     // Core clock period in ns.
  localparam int SCL_PERIOD_NS = 10000;  // One bit on the wire, 100 kHz.
  // A bit is four quarter phases; a longest time rounds down.
  localparam int QTR_CYCLES    = SCL_PERIOD_NS / (4 * CLK_NS);

  // Register offsets on the APB side.
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_WDATA  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_RDATA0 = 12'h010;
  localparam logic [11:0] ADDR_RDATA3 = 12'h01c;

  // Field positions in the control word.
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_RD_BIT   = 1;
  localparam int CTRL_SEL_BIT  = 2;
  localparam int CTRL_TEST_BIT = 3;
  localparam int CTRL_LAST_LSB = 8;

  // Field positions in the status word.
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
  localparam int STAT_DONE_BIT  = 2;
  localparam int STAT_FRESH_BIT = 3;
  localparam int STAT_FIELD_BIT = 4;

  // Decoder write addresses; the read address is one higher.
  localparam logic [7:0] DEV_ADDR_LO = 8'h20;
  localparam logic [7:0] DEV_ADDR_HI = 8'h22;
  localparam logic [3:0] TEST_NIBBLE_MASK = 4'h0; // Upper control bits in use.
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;      // Ninth clock of a byte.

  // Transfer engine states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b10,
    ST_STOP  = 2'b11
  } host_state_t;

  // All state of the main controller.
  typedef struct packed {
    host_state_t  state;     // Engine state.
    logic [1:0]   phase;     // Quarter phase inside a bit.
    logic [3:0]   bitn;      // Bit of the byte, 8 is the acknowledge.
    logic [7:0]   shreg;     // Shift register, both directions.
    logic [3:0]   byte_idx;  // Index of the byte being read.
    logic [3:0]   last_idx;  // Index of the last byte to read.
    logic         is_addr;   // Current byte is the address byte.
    logic         scl_low;   // Clock pulled low.
    logic         sda_low;   // Data pulled low.
    logic         nack;      // Sticky: decoder did not acknowledge.
    logic         done;      // Sticky: last transfer finished.
    logic         rd;        // Transfer reads from the decoder.
    logic         sel;       // Address pair chosen.
    logic         test;      // Decoder test mode requested.
    logic [7:0]   ctrl_byte; // Byte written to the decoder.
    logic [127:0] rbuf;      // Bytes read back, byte 0 lowest.
    logic [31:0]  prdata;    // Read data for the APB access phase.
  } host_regs_t;

endpackage

// [src/pin_sync_if.sv]
// Interface between the pin synchroniser and the controller that reads it.
// Assumes both ends run on the same core clock.
interface pin_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;   // Pin levels as they arrive.
  logic [W-1:0] sync;  // Levels after two flip-flops.
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// [src/pin_sync.sv]
// Two-flop synchroniser for every pin that comes from outside the clock domain.
// Assumes nothing about the pins except that they are levels.
module pin_sync
  import host_pkg::*;
#(
  parameter int W = 4
)(
  input  wire logic     pclk,
  input  wire logic     presetn,
  pin_sync_if.sync_side pins
);

  typedef struct packed {
    logic [W-1:0] meta;   // First stage, read only by the second.
    logic [W-1:0] stable; // Second stage, safe to use.
  } sync_state_t;

  sync_state_t cur_ff;
  sync_state_t nxt_cur;

  // Elaboration check: a synchroniser without bits has nothing to carry.
  if (W < 1)
  begin : g_bad_width
    $error("pin_sync needs at least one bit.");
  end

  // Shift each pin through both stages.
  always_comb
  begin
    nxt_cur        = cur_ff;
    nxt_cur.meta   = pins.raw;
    nxt_cur.stable = cur_ff.meta;
  end

  // Idle bus levels are high, so reset to all ones to avoid a false start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '1;
    else
      cur_ff <= nxt_cur;
  end

  assign pins.sync = cur_ff.stable;

endmodule

// [src/qtr_tick.sv]
// Divider that marks each quarter of a two-wire bit with a one-cycle pulse.
// Assumes the core clock runs continuously.
module qtr_tick
  import host_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
)(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;  // Cycles left in this quarter.
    logic        tick; // Pulse at the end of a quarter.
  } div_state_t;

  div_state_t cur_ff;
  div_state_t nxt_cur;

  // Elaboration check: the counter is 16 bits and needs at least two cycles.
  if (QTR < 2 || QTR > 65535)
  begin : g_bad_qtr
    $error("qtr_tick QTR out of range.");
  end

  // Count down and pulse on wrap; the divider never stops, so phases stay even.
  always_comb
  begin
    nxt_cur      = cur_ff;
    nxt_cur.tick = 1'b0;
    if (cur_ff.cnt == 16'h0000)
    begin
      nxt_cur.cnt  = 16'(QTR - 1);
      nxt_cur.tick = 1'b1;
    end
    else
      nxt_cur.cnt = cur_ff.cnt - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign tick = cur_ff.tick;

endmodule

// [src/vps_line_i2c_host.sv]
// Host controller that drives the line decoder over its two-wire port.
// Assumes software reaches it over APB and that the decoder never stretches clock.
//
// What the document requires of host and decoder
// [R1] Decoder answers 20h/21h or 22h/23h by select.
// [R2] Decoder checks biphase errors on line 16.
// [R3] Decoder copies good bytes to transfer register.
// [R4] Decoder drops data-valid low on fresh bytes.
// [R5] Decoder freezes transfer register during any access.
// [R6] Only the master drives the clock line.
// [R7] Master starts only on an idle bus.
// [R8] Data changes only while clock is low.
// [R9] Write is start, address, ack, byte, ack, stop.
// [R10] Master releases data on ninth clock for ack.
// [R11] Decoder clears its control byte at power-up.
// [R12] Software keeps control bits 4 to 7 zero.
// [R13] Decoder byte counter restarts at each start.
// [R14] Read returns up to 16 bytes, MSB first.
// [R15] Decoder transmits after acknowledging read address.
// [R16] Master ack makes the decoder send next byte.
// [R17] Without master ack the decoder releases data.
// [R18] Master withholds ack on the last wanted byte.
// [R19] Master ends each transfer with a stop.
// [R20] Master opens each transfer with a start.
// [R21] Decoder field output is high in field one.
// [R22] Decoder test mode follows the test input.
// [R23] Decoder sets data-valid high at line 16 start.
// [R24] Decoder forces data-valid high at reset, master no-ack.
// [R25] Field output rises field one, falls field two.
// [R26] Test mode copies select onto both outputs.
// [R27] Decoder ignores addresses outside its pair.
module vps_line_i2c_host
  import host_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        fresh_line_flag_n,
  input  wire logic        first_field_indicator,
  output logic             address_pair_select,
  output logic             test_enable_input
);

  host_regs_t cur_ff;   // Whole controller state.
  host_regs_t nxt_cur;  // Its next value.
  logic       tick;     // Quarter-bit pulse.
  logic       scl_s;    // Synchronised clock line.
  logic       sda_s;    // Synchronised data line.
  logic       fresh_s;  // Synchronised data-valid, active low.
  logic       field_s;  // Synchronised field indicator.
  logic       busy;     // Transfer in progress.
  logic       tx_byte;  // Master sends the current byte.
  logic       wr_acc;   // APB write access phase.
  logic       mapped;   // Address decodes to a register.
  logic [1:0] widx;     // Read-back word index.

  pin_sync_if #(.W(4)) pins ();

  // The decoder side pins are asynchronous to pclk.
  assign pins.raw = {first_field_indicator, fresh_line_flag_n, sda_in, scl_in};
  assign {field_s, fresh_s, sda_s, scl_s} = pins.sync;

  pin_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pins)
  );

  qtr_tick #(.QTR(QTR_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  assign busy    = (cur_ff.state != ST_IDLE);
  assign tx_byte = cur_ff.is_addr || !cur_ff.rd;
  assign wr_acc  = psel && penable && pwrite;
  assign widx    = paddr[3:2];

  // Address decode shared by the read mux and the error answer.
  always_comb
  begin
    if (paddr == ADDR_CTRL)
      mapped = 1'b1;
    else if (paddr == ADDR_WDATA)
      mapped = 1'b1;
    else if (paddr == ADDR_STATUS)
      mapped = 1'b1;
    else if (paddr >= ADDR_RDATA0 && paddr <= ADDR_RDATA3 && paddr[1:0] == 2'b00)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // Register file and transfer engine in one next-state process.
  always_comb
  begin
    nxt_cur = cur_ff;

    // Read data is fetched in the setup cycle so the access phase is zero-wait.
    if (psel && !penable && !pwrite)
    begin
      if (paddr == ADDR_CTRL)
        nxt_cur.prdata = {20'h00000, cur_ff.last_idx, 4'h0,
                          cur_ff.test, cur_ff.sel, cur_ff.rd, 1'b0};
      else if (paddr == ADDR_WDATA)
        nxt_cur.prdata = {24'h000000, cur_ff.ctrl_byte};
      else if (paddr == ADDR_STATUS)
        nxt_cur.prdata = {27'h0000000, field_s, !fresh_s,
                          cur_ff.done, cur_ff.nack, busy};
      else if (mapped)
        nxt_cur.prdata = cur_ff.rbuf[{widx, 5'd0} +: 32];
      else
        nxt_cur.prdata = 32'h00000000;
    end

    // Writes while a transfer runs are ignored, so its settings cannot shift.
    if (wr_acc && !busy)
    begin
      if (paddr == ADDR_CTRL)
      begin
        nxt_cur.rd       = pwdata[CTRL_RD_BIT];
        nxt_cur.sel      = pwdata[CTRL_SEL_BIT];
        nxt_cur.test     = pwdata[CTRL_TEST_BIT];
        nxt_cur.last_idx = pwdata[CTRL_LAST_LSB +: 4];
        if (pwdata[CTRL_GO_BIT])
        begin
          // A new start clears the sticky flags; nothing can set them now.
          nxt_cur.state    = ST_START;
          nxt_cur.phase    = 2'd0;
          nxt_cur.nack     = 1'b0;
          nxt_cur.done     = 1'b0;
          nxt_cur.byte_idx = 4'h0;
        end
      end
      else if (paddr == ADDR_WDATA)
        nxt_cur.ctrl_byte = pwdata[7:0];
    end

    if (tick)
    begin
      case (cur_ff.state)
        ST_IDLE:
        begin
          nxt_cur.scl_low = 1'b0;
          nxt_cur.sda_low = 1'b0;
        end

        ST_START:
        begin
          case (cur_ff.phase)
            2'd0:
            begin
              // Wait here until both lines read high.
              if (scl_s && sda_s)                                       // [R7]
                nxt_cur.phase = 2'd1;
            end
            2'd1:
            begin
              nxt_cur.sda_low = 1'b1;                                   // [R20]
              nxt_cur.phase   = 2'd2;
            end
            default:
            begin
              nxt_cur.scl_low = 1'b1;
              nxt_cur.is_addr = 1'b1;
              nxt_cur.bitn    = 4'h0;
              nxt_cur.phase   = 2'd0;
              nxt_cur.state   = ST_BITS;
              nxt_cur.shreg   = (cur_ff.sel ? DEV_ADDR_HI : DEV_ADDR_LO)
                                | {7'h00, cur_ff.rd};                   // [R1]
            end
          endcase
        end

        ST_BITS:
        begin
          case (cur_ff.phase)
            2'd0:
            begin
              // The clock is low here, so data may move.
              if (cur_ff.bitn != ACK_BIT_IDX)
                nxt_cur.sda_low = tx_byte && !cur_ff.shreg[7];          // [R8]
              else if (tx_byte)
                nxt_cur.sda_low = 1'b0;                                 // [R10]
              else if (cur_ff.byte_idx != cur_ff.last_idx)
                nxt_cur.sda_low = 1'b1;                                 // [R16]
              else
                nxt_cur.sda_low = 1'b0;                                 // [R18]
              nxt_cur.phase = 2'd1;
            end
            2'd1:
            begin
              nxt_cur.scl_low = 1'b0;
              nxt_cur.phase   = 2'd2;
            end
            2'd2:
            begin
              // Sample in mid high time; the ack bit only tells acknowledge.
              if (cur_ff.bitn != ACK_BIT_IDX)
                nxt_cur.shreg = {cur_ff.shreg[6:0], sda_s};
              else if (tx_byte && sda_s)
                nxt_cur.nack = 1'b1;
              nxt_cur.phase = 2'd3;
            end
            default:
            begin
              nxt_cur.scl_low = 1'b1;                                   // [R6]
              nxt_cur.phase   = 2'd0;
              if (cur_ff.bitn != ACK_BIT_IDX)
                nxt_cur.bitn = cur_ff.bitn + 4'h1;
              else
              begin
                nxt_cur.bitn = 4'h0;
                if (tx_byte && cur_ff.nack)
                  nxt_cur.state = ST_STOP;
                else if (cur_ff.is_addr)
                begin
                  nxt_cur.is_addr = 1'b0;
                  // The upper nibble is held at zero unless test is asked for.
                  nxt_cur.shreg   = {cur_ff.test ? cur_ff.ctrl_byte[7:4]
                                                 : TEST_NIBBLE_MASK,
                                     cur_ff.ctrl_byte[3:0]};            // [R12]
                end
                else if (!cur_ff.rd)
                  nxt_cur.state = ST_STOP;                              // [R9]
                else
                begin
                  nxt_cur.rbuf[{cur_ff.byte_idx, 3'd0} +: 8] = cur_ff.shreg; // [R14]
                  if (cur_ff.byte_idx == cur_ff.last_idx)
                    nxt_cur.state = ST_STOP;
                  else
                    nxt_cur.byte_idx = cur_ff.byte_idx + 4'h1;
                end
              end
            end
          endcase
        end

        default:
        begin
          // Stop: data low under low clock, clock up, then data up.
          case (cur_ff.phase)
            2'd0: nxt_cur.sda_low = 1'b1;
            2'd1: nxt_cur.scl_low = 1'b0;
            2'd2: nxt_cur.sda_low = 1'b0;                               // [R19]
            default:
            begin
              nxt_cur.state = ST_IDLE;
              nxt_cur.done  = 1'b1;
            end
          endcase
          nxt_cur.phase = cur_ff.phase + 2'd1;
        end
      endcase
    end
  end

  // One register for the whole state; reset leaves both lines released.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  // Lines are open drain: drive a low only while enabled.
  assign scl_out             = 1'b0;
  assign scl_oe              = cur_ff.scl_low;
  assign sda_out             = 1'b0;
  assign sda_oe              = cur_ff.sda_low;
  assign address_pair_select = cur_ff.sel;
  assign test_enable_input   = cur_ff.test;                             // [R22]
  assign prdata              = cur_ff.prdata;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped;

  // Data moves only under a low clock while bits are sent.
  property p_sda_under_low_scl;
    @(posedge pclk) disable iff (!presetn)
    ($changed(sda_oe) && cur_ff.state == ST_BITS) |-> (scl_oe && $past(scl_oe));
  endproperty
  a_sda_under_low_scl: assert property (p_sda_under_low_scl) // [R8]
    else $error("Data line moved while clock was high.");

  // A start edge is only made after both lines read high.
  property p_start_idle;
    @(posedge pclk) disable iff (!presetn)
    (tick && cur_ff.state == ST_START && cur_ff.phase == 2'd0) ##1
      (cur_ff.phase == 2'd1) |-> $past(scl_s) && $past(sda_s);
  endproperty
  a_start_idle: assert property (p_start_idle) // [R7]
    else $error("Start issued on a busy bus.");

  // Data falling under a high clock happens only as a start.
  property p_start_edge;
    @(posedge pclk) disable iff (!presetn)
    ($rose(sda_oe) && !scl_oe) |-> (cur_ff.state == ST_START);
  endproperty
  a_start_edge: assert property (p_start_edge) // [R20]
    else $error("Data fell under high clock outside a start.");

  // Data rising under a high clock happens only as a stop.
  property p_stop_edge;
    @(posedge pclk) disable iff (!presetn)
    ($fell(sda_oe) && !scl_oe && !$past(scl_oe)) |-> (cur_ff.state == ST_STOP);
  endproperty
  a_stop_edge: assert property (p_stop_edge) // [R19]
    else $error("Data rose under high clock outside a stop.");

  // The master leaves the line free when the decoder acknowledges.
  property p_ack_release;
    @(posedge pclk) disable iff (!presetn)
    (cur_ff.state == ST_BITS && cur_ff.bitn == ACK_BIT_IDX && tx_byte
     && cur_ff.phase != 2'd0) |-> !sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) // [R10]
    else $error("Master drove data during the slave acknowledge.");

  // Last wanted byte is not acknowledged, earlier ones are.
  property p_last_nack;
    @(posedge pclk) disable iff (!presetn)
    (cur_ff.state == ST_BITS && cur_ff.bitn == ACK_BIT_IDX && !tx_byte
     && cur_ff.phase == 2'd2) |-> (sda_oe == (cur_ff.byte_idx != cur_ff.last_idx));
  endproperty
  a_last_nack: assert property (p_last_nack) // [R18]
    else $error("Master acknowledge wrong for this byte.");

  // Clock is only pulled while a transfer runs.
  property p_scl_busy;
    @(posedge pclk) disable iff (!presetn)
    scl_oe |-> busy || $past(busy);
  endproperty
  a_scl_busy: assert property (p_scl_busy) // [R6]
    else $error("Clock held low outside a transfer.");

  // The control byte leaves with a zero upper nibble in normal mode.
  property p_nibble_zero;
    @(posedge pclk) disable iff (!presetn)
    ($fell(cur_ff.is_addr) && !cur_ff.rd && !cur_ff.test) |-> (cur_ff.shreg[7:4] == 4'h0);
  endproperty
  a_nibble_zero: assert property (p_nibble_zero) // [R12]
    else $error("Reserved control bits sent non-zero.");

  // A transfer only finishes through the stop sequence.
  property p_end_by_stop;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> ($past(cur_ff.state) == ST_STOP) && cur_ff.done && !sda_oe && !scl_oe;
  endproperty
  a_end_by_stop: assert property (p_end_by_stop) // [R9]
    else $error("Transfer ended without a stop.");

  property p_cov_write;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) && !cur_ff.rd && !cur_ff.nack;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_read16;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) && cur_ff.rd && cur_ff.last_idx == 4'hf && !cur_ff.nack;
  endproperty
  c_cov_read16: cover property (p_cov_read16);

  property p_cov_nack;
    @(posedge pclk) disable iff (!presetn)
    $rose(cur_ff.nack);
  endproperty
  c_cov_nack: cover property (p_cov_nack);

endmodule

// [bench/vps_decoder_model.sv]
// Behavioural model of the line decoder seen from its two-wire port.
// Assumes resolved wire levels in; it pulls data low only through sda_low.
module vps_decoder_model
(
  input  wire logic         scl,        // Only sensed, never driven.
  input  wire logic         sda,
  output logic              sda_low,
  input  wire logic         sel_pin,
  input  wire logic         test_pin,
  input  wire logic         pin_flip,   // Fault: answer the other address pair.
  input  wire logic         line_start,
  input  wire logic         line_good,  // Line passed the biphase check.
  input  wire logic [127:0] line_data,
  input  wire logic         field_one,
  output logic              fresh_n,
  output logic              field_out,
  output logic [7:0]        ctrl_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] xfer [16];  // Transfer register served to reads.
  logic [7:0] b;          // Byte being received.
  logic [3:0] idx;        // Byte address counter.
  logic       busy_q;     // An access is in progress.
  logic       fresh_q;    // Flag level outside test mode.
  logic       mack;       // Master acknowledged the last byte.

  // Power-up state.
  initial
  begin
    sda_low  = 1'b0;
    busy_q   = 1'b0;
    fresh_q  = 1'b1;
    ctrl_reg = 8'h00;
  end

  // An access freezes the transfer register, so reads stay coherent.
  always @(posedge line_start) fresh_q = 1'b1;
  always @(posedge line_good)
    if (!busy_q)
    begin
      for (int i = 0; i < 16; i++) xfer[i] = line_data[8*i +: 8];
      fresh_q = 1'b0;
    end
  assign fresh_n   = test_pin ? sel_pin : fresh_q;
  assign field_out = test_pin ? sel_pin : field_one;

  task automatic get_byte();
    repeat (8) @(posedge scl) b = {b[6:0], sda};
  endtask

  // One transfer per start; data only changes while the clock is low.
  always
  begin
    @(negedge sda iff scl === 1'b1);
    busy_q = 1'b1;
    idx    = 4'h0;
    get_byte();
    if (b[7:1] == {6'b001000, sel_pin ^ pin_flip})
    begin
      @(negedge scl) sda_low = 1'b1;
      if (b[0])
      begin
        do
        begin
          for (int i = 7; i >= 0; i--)
            @(negedge scl) sda_low = !xfer[idx][i];
          @(negedge scl) sda_low = 1'b0;
          @(posedge scl) mack = !sda;
          idx++;
        end while (mack);
        fresh_q = 1'b1;
      end
      else
      begin
        @(negedge scl) sda_low = 1'b0;
        get_byte();
        @(negedge scl) sda_low = 1'b1;
        @(negedge scl) sda_low = 1'b0;
        ctrl_reg = b;
      end
    end
    @(posedge sda iff scl === 1'b1);
    busy_q = 1'b0;
  end
endmodule

// [bench/vps_line_i2c_host_test.sv]
// Self-checking bench of the line-decoder host controller.
// Assumes the decoder model and pull-ups on both two-wire lines.
module vps_line_i2c_host_test
  import host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} note_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rv;
  logic         scl_out, scl_oe, sda_out, sda_oe, m_sda_low;
  logic         sel_pin, test_pin, pin_flip, line_start, line_good;
  logic         field_one, fresh_n, field_out;
  logic [127:0] line_data, first_data;
  logic [7:0]   ctrl_reg, wbyte;
  int           err_total, comparisons;
  note_t        exp_q[$];
  note_t        n;
  // Open-drain lines: low when anyone pulls, else the pull-up wins.
  wire          scl = scl_oe ? scl_out : 1'b1;
  wire          sda = (sda_oe ? sda_out : 1'b1) & !m_sda_low;

  vps_line_i2c_host DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
    .sda_oe, .fresh_line_flag_n(fresh_n), .first_field_indicator(field_out),
    .address_pair_select(sel_pin), .test_enable_input(test_pin));
  vps_decoder_model model (.scl, .sda, .sda_low(m_sda_low), .sel_pin, .test_pin,
    .pin_flip, .line_start, .line_good, .line_data, .field_one, .fresh_n, .field_out,
    .ctrl_reg);

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = !pclk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Each read answer is matched against the oldest note.
  always @(posedge pclk)
    if ({psel, penable, pready, pwrite} === 4'b1110 && exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      chk({pslverr, prdata & n.m}, {n.e, n.d});
    end

  // One APB transfer; it waits for pready however long that takes.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic e = 1'b0);
    exp_q.push_back({e, d & m, m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 30000; i++)
    begin
      rd(ADDR_STATUS, 32'h0, 32'h0);
      if (rv[STAT_BUSY_BIT] === 1'b0) return;
    end
    err_total++;
    finish_test();
  endtask

  task automatic go(input logic [31:0] c);
    apb(1'b1, ADDR_CTRL, c);
    wait_idle();
  endtask

  // A line 16 arrives with good data.
  task automatic new_line(input logic [127:0] d);
    line_data  <= d;
    line_start <= 1'b1;
    @(posedge pclk);
    line_start <= 1'b0;
    line_good  <= 1'b1;
    @(posedge pclk);
    line_good  <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_flip, line_start, line_good, field_one, line_data} = '0;
    presetn = 1'b0;
    void'($urandom(32'hf048e903));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({25'h0, ctrl_reg}, 33'h0);
    rd(12'h100, 32'h0, 32'hffffffff, 1'b1);
    first_data = {$urandom, $urandom, $urandom, $urandom};
    field_one <= 1'b1;
    new_line(first_data);
    rd(ADDR_STATUS, 32'h18, 32'h18);
    field_one <= 1'b0;
    // Read five bytes; a new line during the access must not land.
    apb(1'b1, ADDR_CTRL, 32'h0403);
    // A write while busy must be dropped, so the byte register stays zero.
    apb(1'b1, ADDR_WDATA, 32'h0000005a);
    repeat (2000) @(posedge pclk);
    new_line({$urandom, $urandom, $urandom, $urandom});
    wait_idle();
    rd(ADDR_STATUS, 32'h04, 32'h1f);
    rd(ADDR_CTRL, 32'h0402, 32'hffffffff);
    rd(ADDR_WDATA, 32'h0, 32'hffffffff);
    rd(ADDR_RDATA0, first_data[31:0], 32'hffffffff);
    // Bytes past the last one asked for keep their reset value.
    rd(ADDR_RDATA0 + 12'h4, {24'h0, first_data[39:32]}, 32'hffffffff);
    rd(ADDR_RDATA3, 32'h0, 32'hffffffff);
    go(32'h0007);
    rd(ADDR_RDATA0, {24'h0, first_data[7:0]}, 32'hff);
    wbyte = 8'($urandom) | 8'hf0;
    apb(1'b1, ADDR_WDATA, {24'h0, wbyte});
    go(32'h0001);
    chk({25'h0, ctrl_reg}, {25'h0, wbyte & 8'h0f});
    wbyte = 8'($urandom);
    apb(1'b1, ADDR_WDATA, {24'h0, wbyte});
    go(32'h000d);
    chk({25'h0, ctrl_reg}, {25'h0, wbyte});
    rd(ADDR_WDATA, {24'h0, wbyte}, 32'hffffffff);
    rd(ADDR_STATUS, 32'h14, 32'h1f);
    pin_flip <= 1'b1;
    go(32'h0001);
    chk({25'h0, ctrl_reg}, {25'h0, wbyte});
    rd(ADDR_STATUS, 32'h02, 32'h03);
    repeat (2) @(posedge pclk);
    // Every noted read must have been answered.
    chk(33'(exp_q.size()), 33'h0);
    finish_test();
  end

  initial
  begin
    // A clean run needs about 64,000 cycles; this allows about 85,000.
    #1_700_000;
    err_total++;
    finish_test();
  end
endmodule
